// File: hw/drs_pkg.sv
/*
  Shared constants for the display record serializer: serial framing,
  record layout offsets, fixed byte values and field limits.
  Assumes a single 25 MHz clock domain for every user of the package.
*/
package drs_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ       = 25000000;    // System clock rate
  localparam int BAUD_RATE    = 2400;        // Serial line rate
  localparam int FRAME_BITS   = 10;          // Start, 8 data, 1 stop
  localparam int DATA_BITS    = 8;           // Data bits per byte

  // ---------------------------------------------------------------
  // Record layout (byte indices)
  // ---------------------------------------------------------------
  localparam logic [6:0] IDX_START   = 7'h00; // Start delimiter
  localparam logic [6:0] IDX_TOTAL   = 7'h01; // Six total digits
  localparam logic [6:0] IDX_TODAY   = 7'h07; // Four daily digits
  localparam logic [6:0] IDX_POWER   = 7'h0B; // Four power digits
  localparam logic [6:0] IDX_PAD1    = 7'h0F; // Sixteen spaces
  localparam logic [6:0] IDX_FILL1   = 7'h1F; // Two zero fillers
  localparam logic [6:0] IDX_IRR     = 7'h21; // Four irradiance digits
  localparam logic [6:0] IDX_FILL2   = 7'h25; // Two zero fillers
  localparam logic [6:0] IDX_PAD2    = 7'h27; // Fifty-six spaces
  localparam logic [6:0] IDX_CR      = 7'h5F; // Carriage return
  localparam logic [6:0] IDX_LF      = 7'h60; // Line feed, last byte
  localparam logic [6:0] REC_LEN     = 7'h61; // 97 bytes in all

  // ---------------------------------------------------------------
  // Byte values
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_START    = 8'h23; // '#'
  localparam logic [7:0] CH_SPACE    = 8'h20; // Padding
  localparam logic [7:0] CH_ZERO     = 8'h30; // Filler and digit base
  localparam logic [7:0] CH_CR       = 8'h0D;
  localparam logic [7:0] CH_LF       = 8'h0A;

  // ---------------------------------------------------------------
  // Sensor selection and field limits
  // ---------------------------------------------------------------
  localparam logic [3:0]  IRR_SENSOR_ADDR = 4'h1;  // Only this unit counts
  localparam logic [19:0] TOTAL_MAX       = 20'hF423F; // 999999
  localparam logic [19:0] FOUR_MAX        = 20'h0270F; // 9999

  // Display type selection
  typedef enum logic {DRS_TYPE_AUTO, DRS_TYPE_RECORD} drs_type_t;

endpackage

// File: hw/drs_serializer.sv
/*
  Display record serializer: builds the fixed 97-byte ASCII energy
  record and sends it on an asynchronous serial transmit line, or in
  the automatic display type detects the attached display variant.
  Assumes binary field values from the monitoring logic on the same
  clock, and a serial receive pin from the display outside the clock.
*/
`timescale 1ns/1ps

// Summary of operation
// - Record mode sends 2400 8N1, no handshake
// - Record is exactly 97 ASCII bytes
// - Total energy: six decimal digits, kWh
// - Daily energy: four decimal digits, kWh
// - Power: four digits, implied point hidden
// - Irradiance: four decimal digits, W/m2
// - Sixteen spaces follow the power field
// - Two zero fillers around irradiance
// - Fifty-six spaces then CR and LF
// - Leading zeros always sent as '0'
// - Missing irradiance sensor encodes as zero
// - Irradiance only from sensor address one
// - Auto type detects display variant unaided
module drs_serializer
  import drs_pkg::*;
#(
  parameter int BAUD_DIV   = CLK_HZ / BAUD_RATE, // Cycles per bit
  parameter int DETECT_DLY = CLK_HZ / BAUD_RATE  // Settle before sampling
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Configuration
  input  wire drs_type_t   display_type,
  // Measured values, binary
  input  wire logic [19:0] total_kwh,
  input  wire logic [19:0] today_kwh,
  input  wire logic [19:0] power_10w,
  // Sensor readings
  input  wire logic        sens_valid,
  input  wire logic [3:0]  sens_addr,
  input  wire logic [19:0] sens_irr,
  input  wire logic        sens_lost,
  // Record request and status
  input  wire logic        send_req,
  output logic             send_ready,
  output logic             busy,
  output logic             record_done,
  // Variant detection
  output logic             variant_valid,
  output logic             variant_id,
  // Serial pins
  input  wire logic        rx_pin,
  output logic             tx_pin
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // ASCII digit of value at a decimal weight, leading zeros kept
  function automatic logic [7:0] dig(input logic [19:0] v,
                                     input logic [19:0] w);
    logic [19:0] q;
    q   = (v / w) % 20'd10;
    dig = CH_ZERO + q[7:0];
  endfunction

  // Clamp a value to its field's largest printable figure
  function automatic logic [19:0] clamp(input logic [19:0] v,
                                        input logic [19:0] m);
    clamp = (v > m) ? m : v;
  endfunction

  // Decimal weight for digit k of an n-digit field (k=0 is leftmost)
  function automatic logic [19:0] weight(input logic [6:0] k,
                                         input logic [6:0] n);
    logic [19:0] w;
    w = 20'h00001;
    for (int i = 0; i < 6; i++) begin
      if (7'(i) < n - k - 7'h01) begin
        w = 20'(w * 20'd10);
      end
    end
    weight = w;
  endfunction

  // ---------------------------------------------------------------
  // Receive pin synchroniser
  // ---------------------------------------------------------------
  logic rx_s1;                 // First stage, read only by rx_s2
  logic rx_s2;                 // Second stage
  logic rx_s3;                 // Third stage
  logic rx_level;              // Agreed level

  // Three stages; a change is taken once stages two and three agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
      rx_s3    <= 1'b1;
      rx_level <= 1'b1;
    end else begin
      rx_s1 <= rx_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) begin
        rx_level <= rx_s3;
      end
    end
  end

  // ---------------------------------------------------------------
  // Variant detection in automatic type
  // ---------------------------------------------------------------
  logic [31:0] det_cnt;        // Settle counter

  // The display's idle line level tells its variant; no setting needed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      det_cnt       <= '0;
      variant_valid <= 1'b0;
      variant_id    <= 1'b0;
    end else if (display_type != DRS_TYPE_AUTO) begin
      det_cnt       <= '0;
      variant_valid <= 1'b0;
    end else if (det_cnt < 32'(DETECT_DLY)) begin
      det_cnt <= det_cnt + 32'h1;
    end else begin
      variant_valid <= 1'b1;
      variant_id    <= rx_level;
    end
  end

  // ---------------------------------------------------------------
  // Irradiance capture
  // ---------------------------------------------------------------
  logic [19:0] irr_val;        // Last reading from address one
  logic        irr_avail;      // Reading present

  // Readings from other sensor units are ignored; sens_lost at any address reads as zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irr_val   <= '0;
      irr_avail <= 1'b0;
    end else if (sens_valid && sens_addr == IRR_SENSOR_ADDR) begin
      irr_val   <= sens_irr;
      irr_avail <= 1'b1;
    end else if (sens_lost) begin
      irr_avail <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Record generator
  // ---------------------------------------------------------------
  logic        gen_active;     // Record in progress
  logic [6:0]  gen_idx;        // Next byte index
  logic [19:0] snap_total;     // Values frozen for one record
  logic [19:0] snap_today;
  logic [19:0] snap_power;
  logic [19:0] snap_irr;
  logic [7:0]  gen_byte;       // Byte at gen_idx
  logic        fifo_in_ready;  // Buffer can take a byte
  logic        gen_push;       // Byte handed to buffer

  assign send_ready = !busy && display_type == DRS_TYPE_RECORD;
  assign gen_push   = gen_active && fifo_in_ready;

  // Snapshot at the start so one record never mixes two updates
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gen_active <= 1'b0;
      gen_idx    <= '0;
      snap_total <= '0;
      snap_today <= '0;
      snap_power <= '0;
      snap_irr   <= '0;
    end else if (send_req && send_ready) begin
      gen_active <= 1'b1;
      gen_idx    <= IDX_START;
      snap_total <= clamp(total_kwh, TOTAL_MAX);
      snap_today <= clamp(today_kwh, FOUR_MAX);
      snap_power <= clamp(power_10w, FOUR_MAX);
      snap_irr   <= irr_avail ? clamp(irr_val, FOUR_MAX) : '0;
    end else if (gen_push) begin
      if (gen_idx == IDX_LF) begin
        gen_active <= 1'b0;
      end
      gen_idx <= gen_idx + 7'h01;
    end
  end

  // Byte for each position; all printable ASCII except the closing CR and LF
  always_comb begin
    if (gen_idx == IDX_START) begin
      gen_byte = CH_START;
    end else if (gen_idx < IDX_TODAY) begin
      gen_byte = dig(snap_total, weight(gen_idx - IDX_TOTAL, 7'h06));
    end else if (gen_idx < IDX_POWER) begin
      gen_byte = dig(snap_today, weight(gen_idx - IDX_TODAY, 7'h04));
    end else if (gen_idx < IDX_PAD1) begin
      gen_byte = dig(snap_power, weight(gen_idx - IDX_POWER, 7'h04));
    end else if (gen_idx < IDX_FILL1) begin
      gen_byte = CH_SPACE;
    end else if (gen_idx < IDX_IRR) begin
      gen_byte = CH_ZERO;
    end else if (gen_idx < IDX_FILL2) begin
      gen_byte = dig(snap_irr, weight(gen_idx - IDX_IRR, 7'h04));
    end else if (gen_idx < IDX_PAD2) begin
      gen_byte = CH_ZERO;
    end else if (gen_idx < IDX_CR) begin
      gen_byte = CH_SPACE;
    end else if (gen_idx == IDX_CR) begin
      gen_byte = CH_CR;
    end else begin
      gen_byte = CH_LF;
    end
  end

  // ---------------------------------------------------------------
  // Two-entry buffer between generator and transmitter
  // ---------------------------------------------------------------
  logic [7:0] fifo_mem [2];    // Storage
  logic       fifo_wp;         // Write pointer
  logic       fifo_rp;         // Read pointer
  logic [1:0] fifo_cnt;        // Occupancy
  logic       fifo_out_valid;  // Byte waiting for transmitter
  logic       fifo_pop;        // Transmitter takes a byte
  logic       fifo_last;       // Popped byte closes a record
  logic [1:0] last_mark;       // Marks which entry holds the LF

  assign fifo_in_ready  = fifo_cnt != 2'h2;
  assign fifo_out_valid = fifo_cnt != 2'h0;

  // Pointers and count; a busy transmitter stalls the generator
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fifo_wp   <= 1'b0;
      fifo_rp   <= 1'b0;
      fifo_cnt  <= '0;
      last_mark <= '0;
    end else begin
      if (gen_push) begin
        fifo_wp            <= !fifo_wp;
        last_mark[fifo_wp] <= gen_idx == IDX_LF;
      end
      if (fifo_pop) begin
        fifo_rp <= !fifo_rp;
      end
      fifo_cnt <= fifo_cnt + {1'b0, gen_push} - {1'b0, fifo_pop};
    end
  end

  // Storage carries no reset; only valid entries are ever read
  always_ff @(posedge clk) begin
    if (gen_push) begin
      fifo_mem[fifo_wp] <= gen_byte;
    end
  end

  assign fifo_last = last_mark[fifo_rp];

  // ---------------------------------------------------------------
  // Serial transmitter
  // ---------------------------------------------------------------
  logic [31:0] baud_cnt;       // Bit timer
  logic        baud_tick;      // One-cycle pulse per bit time
  logic        tx_active;      // Frame on the line
  logic [9:0]  tx_shift;       // Stop, data LSB first, start
  logic [3:0]  tx_bits;        // Bits left in frame
  logic        tx_last;        // Frame carries the closing LF

  assign baud_tick = baud_cnt == 32'(BAUD_DIV - 1);
  assign fifo_pop  = fifo_out_valid && !tx_active;

  // Bit-rate divider, restarted with every frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      baud_cnt <= '0;
    end else if (!tx_active || baud_tick) begin
      baud_cnt <= '0;
    end else begin
      baud_cnt <= baud_cnt + 32'h1;
    end
  end

  // Start bit, eight data bits LSB first, one stop, no parity
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_active <= 1'b0;
      tx_shift  <= '1;
      tx_bits   <= '0;
      tx_last   <= 1'b0;
      tx_pin    <= 1'b1;
    end else if (fifo_pop) begin
      tx_active <= 1'b1;
      tx_shift  <= {1'b1, fifo_mem[fifo_rp], 1'b0};
      tx_bits   <= 4'(FRAME_BITS);
      tx_last   <= fifo_last;
      tx_pin    <= 1'b0;
    end else if (tx_active && baud_tick) begin
      if (tx_bits == 4'h1) begin
        tx_active <= 1'b0;
        tx_pin    <= 1'b1;
      end else begin
        tx_pin <= tx_shift[1];
      end
      tx_shift <= {1'b1, tx_shift[9:1]};
      tx_bits  <= tx_bits - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Status
  // ---------------------------------------------------------------
  // Record ends when the LF stop bit has finished
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      record_done <= 1'b0;
      busy        <= 1'b0;
    end else begin
      record_done <= tx_active && baud_tick && tx_bits == 4'h1 && tx_last;
      if (send_req && send_ready) begin
        busy <= 1'b1;
      end else if (tx_active && baud_tick && tx_bits == 4'h1 && tx_last) begin
        busy <= 1'b0;
      end
    end
  end

endmodule

// File: bench/drs_serializer_sva.sv
/* Port checker for the display record serializer.
   Assumes it is bound onto drs_serializer with the same bit and detect counts. */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module drs_serializer_sva
  import drs_pkg::*;
#(
  parameter int BAUD_DIV   = 8, // Clocks per serial bit
  parameter int DETECT_DLY = 8  // Settle time before detection
) (
  // Clock and reset
  input wire logic      clk,
  input wire logic      rst_b,
  // Mode and request
  input wire drs_type_t display_type,
  input wire logic      send_req,
  // Status and serial out
  input wire logic      send_ready,
  input wire logic      busy,
  input wire logic      record_done,
  input wire logic      variant_valid,
  input wire logic      tx_pin
);
  int low_run;  // Cycles the line has stayed low
  int auto_run; // Cycles spent in automatic mode, saturating
  // Run counters; a property cannot count past eight cycles cheaply
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_run  <= 0;
      auto_run <= 0;
    end else begin
      low_run  <= tx_pin ? 0 : low_run + 1;
      auto_run <= (display_type == DRS_TYPE_RECORD) ? 0 : auto_run + int'(auto_run < 1000);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_idle_high; !busy |-> tx_pin; endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("line low while idle");
  property p_low_bits; $rose(tx_pin) |-> low_run > 0 && low_run % BAUD_DIV == 0; endproperty
  a_low_bits: assert property (p_low_bits)
    else $error("low run not whole bits");
  property p_start; send_req && send_ready |=> busy ##2 !tx_pin; endproperty
  a_start: assert property (p_start)
    else $error("start bit late");
  property p_done_pulse; record_done |=> !record_done; endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than one cycle");
  property p_done_ends; record_done |-> ##[0:1] !busy; endproperty
  a_done_ends: assert property (p_done_ends)
    else $error("busy after done");
  property p_busy_hold; $fell(busy) |-> record_done || $past(record_done); endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped early");
  property p_ready; send_ready |-> display_type == DRS_TYPE_RECORD && !busy; endproperty
  a_ready: assert property (p_ready)
    else $error("ready in wrong state");
  property p_no_variant; (display_type == DRS_TYPE_RECORD) [*2] |-> !variant_valid; endproperty
  a_no_variant: assert property (p_no_variant)
    else $error("variant kept in record mode");
  property p_detect; auto_run > DETECT_DLY + 8 |-> variant_valid; endproperty
  a_detect: assert property (p_detect)
    else $error("variant not detected");
endmodule

bind drs_serializer drs_serializer_sva #(.BAUD_DIV(BAUD_DIV), .DETECT_DLY(DETECT_DLY)) u_sva (
  .clk(clk), .rst_b(rst_b), .display_type(display_type), .send_req(send_req),
  .send_ready(send_ready), .busy(busy), .record_done(record_done),
  .variant_valid(variant_valid), .tx_pin(tx_pin));

// File: bench/drs_display_model.sv
/* Behavioural large display at the far end of the serial line.
   Assumes 8N1 frames at BAUD_DIV clocks per bit on tx_pin. */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Display model
// ------------------------------------------------------------
module drs_display_model #(
  parameter int BAUD_DIV = 8 // Clocks per serial bit
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Serial lines
  input  wire logic tx_pin,
  input  wire logic variant_lvl,
  output logic      rx_pin
);
  logic [7:0] byte_q[$]; // Bytes received, in order
  logic       frame_err; // Bad start or stop bit seen
  logic [7:0] shift;     // Byte being assembled
  // Idle level of the return line marks the variant
  assign rx_pin = variant_lvl;
  // Sample mid-bit, LSB first, no parity, one stop bit
  initial begin
    frame_err = 1'b0;
    shift     = 8'h00;
    forever begin
      @(posedge clk);
      if (rst_b && tx_pin === 1'b0) begin
        repeat (BAUD_DIV / 2) @(posedge clk);
        if (tx_pin !== 1'b0) frame_err = 1'b1;
        for (int i = 0; i < 8; i++) begin
          repeat (BAUD_DIV) @(posedge clk);
          shift[i] = tx_pin;
        end
        repeat (BAUD_DIV) @(posedge clk);
        if (tx_pin !== 1'b1) frame_err = 1'b1;
        byte_q.push_back(shift);
      end
    end
  end
endmodule

// File: bench/drs_serializer_tb.sv
/* Self-checking bench for the display record serializer.
   Assumes drs_pkg and the display model; bit and detect counts shortened to 8. */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module drs_serializer_tb import drs_pkg::*;;
  localparam int BD = 8; // Short bit time keeps the run brief
  logic        clk, rst_b, s_valid, s_lost, send_req, vlvl; // Stimulus
  drs_type_t   dtype;                                       // Display type
  logic [19:0] total, today, power, s_irr;                  // Field values
  logic [3:0]  s_addr;                                      // Sensor address
  logic        send_ready, busy, record_done, variant_valid, variant_id, rx_pin, tx_pin;
  logic [2:0]  flags;                                       // Waitable flags
  logic [7:0]  exp_q[$];                                    // Expected bytes
  int          n_fail, n_tests;
  assign flags = {variant_valid, record_done, send_ready};
  drs_serializer #(.BAUD_DIV(BD), .DETECT_DLY(BD)) uut (.clk(clk), .rst_b(rst_b),
    .display_type(dtype), .total_kwh(total), .today_kwh(today), .power_10w(power),
    .sens_valid(s_valid), .sens_addr(s_addr), .sens_irr(s_irr), .sens_lost(s_lost),
    .send_req(send_req), .send_ready(send_ready), .busy(busy), .record_done(record_done),
    .variant_valid(variant_valid), .variant_id(variant_id), .rx_pin(rx_pin), .tx_pin(tx_pin));
  drs_display_model #(.BAUD_DIV(BD)) disp (.clk(clk), .rst_b(rst_b), .tx_pin(tx_pin),
    .variant_lvl(vlvl), .rx_pin(rx_pin));
  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait on one flag; a hang ends the run
  task automatic wait_hi(input int b);
    int k;
    k = 0;
    while (flags[b] !== 1'b1) begin
      @(negedge clk);
      k++;
      if (k > 12000) begin
        n_fail++;
        tally_and_finish();
      end
    end
  endtask
  function automatic void push_dec(input int v, input int n);
    for (int i = n - 1; i >= 0; i--) exp_q.push_back(8'h30 + 8'((v / (10 ** i)) % 10));
  endfunction
  // Whole expected record, delimiter to terminator
  function automatic void build(input int t, input int d, input int p, input int r);
    exp_q = {8'h23};
    push_dec(t, 6);
    push_dec(d, 4);
    push_dec(p, 4);
    repeat (16) exp_q.push_back(8'h20);
    repeat (2) exp_q.push_back(8'h30);
    push_dec(r, 4);
    repeat (2) exp_q.push_back(8'h30);
    repeat (56) exp_q.push_back(8'h20);
    exp_q.push_back(8'h0D);
    exp_q.push_back(8'h0A);
  endfunction
  task automatic sensor(input logic [3:0] a, input int v, input logic lost);
    s_addr  = a;
    s_irr   = v[19:0];
    s_valid = !lost;
    s_lost  = lost;
    @(negedge clk);
    s_valid = 1'b0;
    s_lost  = 1'b0;
  endtask
  // Request one record and compare every byte the display got
  task automatic rec(input int t, input int d, input int p, input int r);
    total = t[19:0];
    today = d[19:0];
    power = p[19:0];
    build(t > 999999 ? 999999 : t, d > 9999 ? 9999 : d, p, r);
    disp.byte_q.delete();
    wait_hi(0);
    send_req = 1'b1;
    @(negedge clk);
    send_req = 1'b0;
    check(busy, 1'b1);
    wait_hi(1);
    check(disp.byte_q.size(), 97);
    for (int i = 0; i < 97; i++) check(disp.byte_q[i], exp_q[i]);
    check(disp.frame_err, 1'b0);
  endtask
  // Leading zeros, layout, only address one feeds irradiance
  task automatic sc_layout();
    sensor(4'h1, 850, 1'b0);
    sensor(4'h2, 777, 1'b0);
    rec(42, 7, 1234, 850);
  endtask
  // Lost sensor reads zero; a request while busy is dropped
  task automatic sc_missing();
    sensor(4'h1, 0, 1'b1);
    fork
      rec(1048575, 20000, 9999, 0);
      begin
        repeat (300) @(negedge clk);
        send_req = 1'b1;
        @(negedge clk);
        send_req = 1'b0;
      end
    join
    repeat (30) @(negedge clk);
    check(busy, 1'b0);
    check(disp.byte_q.size(), 97);
    rec(0, 0, 5, 0);
  endtask
  // Automatic type: no record, variant taken from the line level
  task automatic sc_auto();
    for (int v = 0; v < 2; v++) begin
      vlvl  = v[0];
      dtype = DRS_TYPE_AUTO;
      @(negedge clk);
      check(send_ready, 1'b0);
      send_req = 1'b1;
      wait_hi(2);
      repeat (20) @(negedge clk);
      send_req = 1'b0;
      check(variant_valid, 1'b1);
      check(busy, 1'b0);
      check(variant_id, v[0]);
      dtype = DRS_TYPE_RECORD;
      repeat (3) @(negedge clk);
      check(variant_valid, 1'b0);
    end
  endtask
  // Reset in mid-record: line idles high, status clears, next record whole
  task automatic sc_reset();
    wait_hi(0);
    send_req = 1'b1;
    @(negedge clk);
    send_req = 1'b0;
    repeat (200) @(negedge clk);
    rst_b = 1'b0;
    @(negedge clk);
    check(tx_pin, 1'b1);
    check(busy, 1'b0);
    check(send_ready, 1'b1);
    rst_b = 1'b1;
    repeat (100) @(negedge clk);
    rec(3, 2, 1, 0);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Main sequence: reset for 20 cycles, then the scenarios
  initial begin
    rst_b    = 1'b0;
    s_valid  = 1'b0;
    s_lost   = 1'b0;
    send_req = 1'b0;
    s_addr   = 4'h0;
    s_irr    = 20'h00000;
    total    = 20'h00000;
    today    = 20'h00000;
    power    = 20'h00000;
    dtype   = DRS_TYPE_RECORD;
    vlvl    = 1'b1;
    n_fail  = 0;
    n_tests = 0;
    repeat (20) @(negedge clk);
    check(tx_pin, 1'b1);
    rst_b = 1'b1;
    sc_layout();
    sc_missing();
    sc_reset();
    sc_auto();
    tally_and_finish();
  end
endmodule
